// ### rtl/can_slice_defs.svh
// register offsets, field positions and reset values of the can status and filter slice
// assumes a 16-bit register port addressed by word index
`ifndef CAN_SLICE_DEFS_SVH
`define CAN_SLICE_DEFS_SVH

`define OFS_RX_ERR_COUNT 8'h00
`define OFS_TX_ERR_COUNT 8'h01
`define OFS_UNREAD_FLAGS 8'h02
`define OFS_MASK_LOW 8'h03
`define OFS_MASK_HIGH 8'h04
`define OFS_MB0_ID_LOW 8'h05
`define OFS_MB0_ID_HIGH 8'h06
`define OFS_RX_PENDING 8'h07
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_MASK 8'h09
`define OFS_MB_SELECT 8'h0a
`define OFS_MB_ID_LOW 8'h0b
`define OFS_MB_ID_HIGH 8'h0c

`define MASK_HIGH_RSVD 16'h1c00
`define MB0_ID_HIGH_IDE_BIT 10
`define IRQ_BIT_UNREAD 0
`define IRQ_BIT_RX_MSG 1
`define IRQ_STATUS_BITS 16'h0003
`define IRQ_MASK_RESET 16'h0003
`define ERR_STEP_SMALL 8'h01
`define ERR_STEP_LARGE 8'h08
`define ERR_PASSIVE_LIMIT 8'h7f
`define REC_PASSIVE_RETURN 8'h77

`endif

// ### rtl/can_slice_pkg.sv
// types shared by the can status and filter slice
// assumes nothing beyond the defs header
`default_nettype none
package can_slice_pkg;
    typedef logic [15:0] word_t;
    typedef logic [28:0] can_id_t;
    typedef logic [3:0] mb_index_t;
    typedef logic [7:0] err_count_t;
endpackage
`default_nettype wire

// ### rtl/mailbox_id_store.sv
// sixteen-entry store of the last accepted identifier per mailbox
// assumes one write port and one read port on the same clock
`default_nettype none
module mailbox_id_store
    import can_slice_pkg::*;
(
    input wire logic clk,
    input wire logic wr_en,
    input wire mb_index_t wr_addr,
    input wire logic [31:0] wr_data,
    input wire mb_index_t rd_addr,
    output logic [31:0] rd_data
);
    logic [31:0] mem [0:15];

    // a new write simply replaces the old entry
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// ### rtl/can_err_unread_filter.sv
// error counters, unread-overwrite flags and mailbox 0 acceptance mask of a can controller
// assumes the protocol engine reports error and success events as one-cycle pulses
// and reports each completed reception with its mailbox, identifier and format
//
// Added by the designer: the address-and-strobe port and the address map.
`include "can_slice_defs.svh"
`default_nettype none

module can_err_unread_filter
    import can_slice_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [7:0] ADDR,
    input wire word_t WDATA,
    input wire logic WR,
    input wire logic RD,
    output word_t RDATA,
    input wire logic RX_ERR,
    input wire logic RX_ERR_DOM,
    input wire logic RX_OK,
    input wire logic TX_ERR,
    input wire logic TX_OK,
    input wire logic RX_DONE,
    input wire mb_index_t RX_MB,
    input wire can_id_t RX_ID,
    input wire logic RX_IDE,
    output word_t RX_PENDING,
    output logic IRQ
);
    err_count_t rec_ff, nxt_rec, tec_ff, nxt_tec;
    word_t pend_ff, nxt_pend, ovw_ff, nxt_ovw;
    word_t mlow_ff, nxt_mlow, mhigh_ff, nxt_mhigh;
    word_t idlow_ff, nxt_idlow, idhigh_ff, nxt_idhigh;
    word_t ist_ff, nxt_ist, imask_ff, nxt_imask;
    mb_index_t sel_ff, nxt_sel;
    word_t rdata_ff, nxt_rdata;
    logic irq_ff, nxt_irq;
    can_id_t mask_id, ref_id, mask_eff;
    logic ref_ide, mb0_match, store_en, overwrite_evt;
    word_t store_hit, ovw_view, ovw_clear, pend_clear;
    logic [31:0] mem_q;

    // error counters with saturation at both ends
    function automatic err_count_t sat_add(err_count_t v, err_count_t s);
        logic [8:0] sum;
        sum = {1'b0, v} + {1'b0, s};
        return sum[8] ? 8'hff : sum[7:0];
    endfunction

    always_comb begin
        nxt_rec = rec_ff;
        nxt_tec = tec_ff;
        if (RX_ERR_DOM) begin
            nxt_rec = sat_add(rec_ff, `ERR_STEP_LARGE);
        end else if (RX_ERR) begin
            nxt_rec = sat_add(rec_ff, `ERR_STEP_SMALL);
        end else if (RX_OK && rec_ff > `ERR_PASSIVE_LIMIT) begin
            nxt_rec = `REC_PASSIVE_RETURN;
        end else if (RX_OK && rec_ff != 8'h00) begin
            nxt_rec = rec_ff - `ERR_STEP_SMALL;
        end
        if (TX_ERR) begin
            nxt_tec = sat_add(tec_ff, `ERR_STEP_LARGE);
        end else if (TX_OK && tec_ff != 8'h00) begin
            nxt_tec = tec_ff - `ERR_STEP_SMALL;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rec_ff <= 8'h00;
            tec_ff <= 8'h00;
        end else begin
            rec_ff <= nxt_rec;
            tec_ff <= nxt_tec;
        end
    end

    // unscramble mask and reference identifier into plain id bit order
    assign mask_id = {mhigh_ff[7:0], mhigh_ff[15:13], mhigh_ff[9:8],
                      mlow_ff[7:0], mlow_ff[15:8]};
    assign ref_id = {idhigh_ff[7:0], idhigh_ff[15:13], idhigh_ff[9:8],
                     idlow_ff[7:0], idlow_ff[15:8]};
    assign ref_ide = idhigh_ff[`MB0_ID_HIGH_IDE_BIT];

    // mailbox 0 acceptance: masked bits are not compared
    always_comb begin
        mask_eff = RX_IDE ? mask_id : {mask_id[28:18], 18'h3ffff};
        mb0_match = (RX_IDE == ref_ide) && (((RX_ID ^ ref_id) & ~mask_eff) == 29'h0);
        store_en = RX_DONE && ((RX_MB != 4'h0) || mb0_match);
    end

    // software clears; only the unread-flag clear is remapped from register layout into mailbox order
    always_comb begin
        ovw_clear = 16'h0000;
        pend_clear = 16'h0000;
        if (WR && ADDR == `OFS_UNREAD_FLAGS) begin
            ovw_clear = {WDATA[7:0], WDATA[15:8]};
        end
        if (WR && ADDR == `OFS_RX_PENDING) begin
            pend_clear = WDATA;
        end
    end

    // per-mailbox pending and overwrite flags; a new event beats a same-cycle clear
    for (genvar i = 0; i < 16; i++) begin : g_mb
        assign store_hit[i] = store_en && (RX_MB == mb_index_t'(i));
        always_comb begin
            nxt_pend[i] = store_hit[i] | (pend_ff[i] & ~pend_clear[i]);
            nxt_ovw[i] = (store_hit[i] & pend_ff[i]) | (ovw_ff[i] & ~ovw_clear[i]);
        end
    end

    assign overwrite_evt = |(store_hit & pend_ff);
    assign ovw_view = {ovw_ff[7:0], ovw_ff[15:8]};

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            pend_ff <= 16'h0000;
            ovw_ff <= 16'h0000;
        end else begin
            pend_ff <= nxt_pend;
            ovw_ff <= nxt_ovw;
        end
    end

    // identifier store; an overwrite replaces the old entry for good
    mailbox_id_store u_store (
        .clk(CLK),
        .wr_en(store_en),
        .wr_addr(RX_MB),
        .wr_data({1'b0, RX_IDE, 1'b0, RX_ID}),
        .rd_addr(sel_ff),
        .rd_data(mem_q)
    );

    // control registers and interrupt status
    always_comb begin
        nxt_mlow = mlow_ff;
        nxt_mhigh = mhigh_ff;
        nxt_idlow = idlow_ff;
        nxt_idhigh = idhigh_ff;
        nxt_imask = imask_ff;
        nxt_sel = sel_ff;
        nxt_ist = ist_ff;
        if (WR) begin
            unique case (ADDR)
                `OFS_MASK_LOW: nxt_mlow = WDATA;
                `OFS_MASK_HIGH: nxt_mhigh = WDATA & ~`MASK_HIGH_RSVD;
                `OFS_MB0_ID_LOW: nxt_idlow = WDATA;
                `OFS_MB0_ID_HIGH: nxt_idhigh = WDATA;
                `OFS_IRQ_MASK: nxt_imask = WDATA & `IRQ_STATUS_BITS;
                `OFS_MB_SELECT: nxt_sel = WDATA[3:0];
                `OFS_IRQ_STATUS: nxt_ist = ist_ff & ~WDATA;
                default: ;
            endcase
        end
        if (overwrite_evt) begin
            nxt_ist[`IRQ_BIT_UNREAD] = 1'b1;
        end
        if (store_en) begin
            nxt_ist[`IRQ_BIT_RX_MSG] = 1'b1;
        end
        nxt_irq = |(nxt_ist & ~nxt_imask);
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            mlow_ff <= 16'h0000;
            mhigh_ff <= 16'h0000;
            idlow_ff <= 16'h0000;
            idhigh_ff <= 16'h0000;
            imask_ff <= `IRQ_MASK_RESET;
            sel_ff <= 4'h0;
            ist_ff <= 16'h0000;
            irq_ff <= 1'b0;
        end else begin
            mlow_ff <= nxt_mlow;
            mhigh_ff <= nxt_mhigh;
            idlow_ff <= nxt_idlow;
            idhigh_ff <= nxt_idhigh;
            imask_ff <= nxt_imask;
            sel_ff <= nxt_sel;
            ist_ff <= nxt_ist;
            irq_ff <= nxt_irq;
        end
    end

    // read mux, registered; unmapped offsets read as zero
    always_comb begin
        nxt_rdata = 16'h0000;
        if (RD) begin
            unique case (ADDR)
                `OFS_RX_ERR_COUNT: nxt_rdata = {8'h00, rec_ff};
                `OFS_TX_ERR_COUNT: nxt_rdata = {8'h00, tec_ff};
                `OFS_UNREAD_FLAGS: nxt_rdata = ovw_view;
                `OFS_MASK_LOW: nxt_rdata = mlow_ff;
                `OFS_MASK_HIGH: nxt_rdata = mhigh_ff & ~`MASK_HIGH_RSVD;
                `OFS_MB0_ID_LOW: nxt_rdata = idlow_ff;
                `OFS_MB0_ID_HIGH: nxt_rdata = idhigh_ff;
                `OFS_RX_PENDING: nxt_rdata = pend_ff;
                `OFS_IRQ_STATUS: nxt_rdata = ist_ff;
                `OFS_IRQ_MASK: nxt_rdata = imask_ff;
                `OFS_MB_SELECT: nxt_rdata = {12'h000, sel_ff};
                `OFS_MB_ID_LOW: nxt_rdata = mem_q[15:0];
                `OFS_MB_ID_HIGH: nxt_rdata = mem_q[31:16];
                default: nxt_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign RDATA = rdata_ff;
    assign RX_PENDING = pend_ff;
    assign IRQ = irq_ff;

    // checks on the behaviour above
    a_rec_step_up: assert property (@(posedge CLK) disable iff (RESET)
        RX_ERR && !RX_ERR_DOM && rec_ff < 8'hff |=> rec_ff == $past(rec_ff) + 8'h01)
        else $error("receive count did not step by one");
    a_tec_step_up: assert property (@(posedge CLK) disable iff (RESET)
        TX_ERR && tec_ff < 8'hf8 |=> tec_ff == $past(tec_ff) + 8'h08)
        else $error("transmit count did not step by eight");
    a_ovw_set_pend: assert property (@(posedge CLK) disable iff (RESET)
        store_en && pend_ff[RX_MB] |=> ovw_ff[$past(RX_MB)])
        else $error("overwrite flag missed");
    a_ovw_no_cause: assert property (@(posedge CLK) disable iff (RESET)
        $rose(ovw_ff[5]) |-> $past(store_en && RX_MB == 4'h5 && pend_ff[5]))
        else $error("overwrite flag set without cause");
    a_ovw_zero_write: assert property (@(posedge CLK) disable iff (RESET)
        WR && ADDR == `OFS_UNREAD_FLAGS && WDATA == 16'h0000 && ovw_ff != 16'h0000
        |=> ovw_ff != 16'h0000)
        else $error("writing zero cleared a flag");
    a_ovw_layout: assert property (@(posedge CLK) disable iff (RESET)
        RD && ADDR == `OFS_UNREAD_FLAGS |=> RDATA[15] == $past(ovw_ff[7]) &&
        RDATA[0] == $past(ovw_ff[8]))
        else $error("overwrite register layout wrong");
    a_mb0_exact: assert property (@(posedge CLK) disable iff (RESET)
        RX_DONE && RX_MB == 4'h0 && mask_id == 29'h0 && RX_IDE && ref_ide &&
        RX_ID != ref_id |=> !pend_ff[0] || $past(pend_ff[0]))
        else $error("unmasked mismatch accepted into mailbox 0");
    a_mask_rsvd: assert property (@(posedge CLK) disable iff (RESET)
        RD && ADDR == `OFS_MASK_HIGH |=> RDATA[12:10] == 3'h0)
        else $error("reserved mask bits read nonzero");
    a_pend_on_store: assert property (@(posedge CLK) disable iff (RESET)
        store_en |=> pend_ff[$past(RX_MB)] ##1 1'b1)
        else $error("pending flag not set on reception");
    a_irq_masked: assert property (@(posedge CLK) disable iff (RESET)
        imask_ff == `IRQ_STATUS_BITS && $past(imask_ff == `IRQ_STATUS_BITS) |-> !IRQ)
        else $error("masked interrupt reached output");
    a_std_ignores_ext: assert property (@(posedge CLK) disable iff (RESET)
        RX_DONE && RX_MB == 4'h0 && !RX_IDE && !ref_ide &&
        ((RX_ID ^ ref_id) & {mask_id[28:18] ^ 11'h7ff, 18'h0}) == 29'h0 |-> mb0_match)
        else $error("standard message rejected on extended bits");

    // counter steps, clear by a written one, interrupt level and mask bit placement
    a_rec_dom_step: assert property (@(posedge CLK) disable iff (RESET)
        RX_ERR_DOM && rec_ff < 8'hf8 |=> rec_ff == $past(rec_ff) + 8'h08)
        else $error("receive count did not step by eight");
    a_rec_passive_back: assert property (@(posedge CLK) disable iff (RESET)
        RX_OK && !RX_ERR && !RX_ERR_DOM && rec_ff > `ERR_PASSIVE_LIMIT |=> rec_ff == 8'h77)
        else $error("receive count did not return from passive");
    a_tec_step_down: assert property (@(posedge CLK) disable iff (RESET)
        TX_OK && !TX_ERR && tec_ff != 8'h00 |=> tec_ff == $past(tec_ff) - 8'h01)
        else $error("transmit count did not step down");
    a_ovw_one_clear: assert property (@(posedge CLK) disable iff (RESET)
        WR && ADDR == `OFS_UNREAD_FLAGS && WDATA[13] && !overwrite_evt |=> !ovw_ff[5])
        else $error("written one did not clear the flag");
    a_irq_unread_up: assert property (@(posedge CLK) disable iff (RESET)
        ist_ff[`IRQ_BIT_UNREAD] && !imask_ff[`IRQ_BIT_UNREAD] |-> IRQ)
        else $error("unmasked unread interrupt missing");
    a_mask_low_map: assert property (@(posedge CLK) disable iff (RESET)
        WR && ADDR == `OFS_MASK_LOW |=> mask_id[7:0] == $past(WDATA[15:8]) &&
        mask_id[15:8] == $past(WDATA[7:0]))
        else $error("low mask bits land on wrong identifier bits");
    a_mask_high_map: assert property (@(posedge CLK) disable iff (RESET)
        WR && ADDR == `OFS_MASK_HIGH |=> mask_id[28:21] == $past(WDATA[7:0]) &&
        mask_id[20:18] == $past(WDATA[15:13]) && mask_id[17:16] == $past(WDATA[9:8]))
        else $error("high mask bits land on wrong identifier bits");

    c_overwrite: cover property (@(posedge CLK) disable iff (RESET) overwrite_evt);
    c_mb0_masked: cover property (@(posedge CLK) disable iff (RESET)
        RX_DONE && RX_MB == 4'h0 && mb0_match && mask_id != 29'h0);
    c_irq_up: cover property (@(posedge CLK) disable iff (RESET) $rose(IRQ));
    c_set_beats_clear: cover property (@(posedge CLK) disable iff (RESET)
        overwrite_evt && WR && ADDR == `OFS_UNREAD_FLAGS);
endmodule
`default_nettype wire

// ### tb/can_node_model.sv
// model of the other nodes on the can bus, seen through the protocol engine's event pulses
// assumes the bench calls its tasks from one process and that clk is the controller clock
`default_nettype none
module can_node_model
    import can_slice_pkg::*;
(
    input wire logic clk,
    output logic [4:0] events,
    output logic rx_done,
    output mb_index_t rx_mb,
    output can_id_t rx_id,
    output logic rx_ide
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus: no events, frame fields start at zero
    initial begin
        events = '0;
        rx_done = 1'b0;
        rx_mb = '0;
        rx_id = '0;
        rx_ide = 1'b0;
    end

    // one-cycle pulse of the selected events: tx_ok, tx_err, rx_ok, rx_err_dom, rx_err
    task automatic pulse(input logic [4:0] sel);
        @(posedge clk);
        events <= sel;
        @(posedge clk);
        events <= '0;
    endtask

    // a completed reception; afterwards the fields are scrambled so stale values never match
    task automatic frame(input mb_index_t mb, input can_id_t id, input logic ide);
        @(posedge clk);
        rx_done <= 1'b1;
        rx_mb <= mb;
        rx_id <= id;
        rx_ide <= ide;
        @(posedge clk);
        rx_done <= 1'b0;
        rx_mb <= ~mb;
        rx_id <= ~id;
        rx_ide <= ~ide;
    endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench of the can error, unread-overwrite and mailbox 0 filter slice
// assumes the register map of the defs header and a node model driving the event inputs
`include "can_slice_defs.svh"
`default_nettype none
module testbench import can_slice_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = '0;
    word_t wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    word_t rdata;
    word_t rx_pending;
    logic irq;
    logic [4:0] events;
    logic rx_done;
    mb_index_t rx_mb;
    can_id_t rx_id;
    logic rx_ide;
    int errors = 0;
    int check_count = 0;
    can_id_t rid = 29'h0aaa5555;
    logic [31:0] w;

    always #5 clk = ~clk;

    can_err_unread_filter i_can_err_unread_filter (.CLK(clk), .RESET(reset), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RX_ERR(events[0]),
        .RX_ERR_DOM(events[1]), .RX_OK(events[2]), .TX_ERR(events[3]), .TX_OK(events[4]),
        .RX_DONE(rx_done), .RX_MB(rx_mb), .RX_ID(rx_id), .RX_IDE(rx_ide),
        .RX_PENDING(rx_pending), .IRQ(irq));

    can_node_model node (.clk(clk), .events(events), .rx_done(rx_done), .rx_mb(rx_mb),
        .rx_id(rx_id), .rx_ide(rx_ide));

    // identifier to {high, low} register layout shared by masks and reference id
    function automatic logic [31:0] map_id(input can_id_t id, input logic ide);
        map_id = {id[20:18], 2'b00, ide, id[17:16], id[28:21], id[7:0], id[15:8]};
    endfunction

    task automatic chk_word(input word_t got, input word_t exp, input string msg);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t %s got %b exp %b", $time, msg, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input word_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input word_t exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk_word(rdata, exp, "register read");
    endtask

    task automatic irq_chk(input logic exp);
        @(posedge clk);
        #1;
        chk_bit(irq, exp, "interrupt level");
    endtask

    task automatic test_reset();
        rd_chk(`OFS_RX_ERR_COUNT, 16'h0000);
        rd_chk(`OFS_TX_ERR_COUNT, 16'h0000);
        rd_chk(`OFS_UNREAD_FLAGS, 16'h0000);
        rd_chk(`OFS_MASK_LOW, 16'h0000);
        rd_chk(`OFS_MASK_HIGH, 16'h0000);
        rd_chk(`OFS_IRQ_MASK, 16'h0003);
        rd_chk(8'h3f, 16'h0000);
        wr_reg(`OFS_MASK_HIGH, 16'he3ff);
        rd_chk(`OFS_MASK_HIGH, 16'he3ff);
        wr_reg(`OFS_MASK_HIGH, 16'h0000);
        $display("test reset done");
    endtask

    task automatic test_counters();
        repeat (3) node.pulse(5'h01);
        node.pulse(5'h03);
        rd_chk(`OFS_RX_ERR_COUNT, 16'h000b);
        node.pulse(5'h04);
        wr_reg(`OFS_RX_ERR_COUNT, 16'h00ff);
        rd_chk(`OFS_RX_ERR_COUNT, 16'h000a);
        repeat (2) node.pulse(5'h08);
        node.pulse(5'h10);
        rd_chk(`OFS_TX_ERR_COUNT, 16'h000f);
        node.pulse(5'h18);
        rd_chk(`OFS_TX_ERR_COUNT, 16'h0017);
        repeat (15) node.pulse(5'h02);
        rd_chk(`OFS_RX_ERR_COUNT, 16'h0082);
        node.pulse(5'h04);
        rd_chk(`OFS_RX_ERR_COUNT, 16'h0077);
        $display("test counters done");
    endtask

    task automatic test_overwrite();
        node.frame(4'h5, 29'h00001234, 1'b1);
        rd_chk(`OFS_RX_PENDING, 16'h0020);
        rd_chk(`OFS_UNREAD_FLAGS, 16'h0000);
        node.frame(4'h5, 29'h00005678, 1'b1);
        node.frame(4'h9, 29'h00000001, 1'b0);
        node.frame(4'h9, 29'h00000002, 1'b0);
        rd_chk(`OFS_UNREAD_FLAGS, 16'h2002);
        wr_reg(`OFS_UNREAD_FLAGS, 16'h0000);
        rd_chk(`OFS_UNREAD_FLAGS, 16'h2002);
        wr_reg(`OFS_UNREAD_FLAGS, 16'h2000);
        rd_chk(`OFS_UNREAD_FLAGS, 16'h0002);
        wr_reg(`OFS_MB_SELECT, 16'h0005);
        @(posedge clk);
        rd_chk(`OFS_MB_ID_LOW, 16'h5678);
        rd_chk(`OFS_MB_ID_HIGH, 16'h4000);
        irq_chk(1'b0);
        wr_reg(`OFS_IRQ_MASK, 16'h0002);
        irq_chk(1'b1);
        wr_reg(`OFS_IRQ_MASK, 16'h0003);
        irq_chk(1'b0);
        rd_chk(`OFS_IRQ_STATUS, 16'h0003);
        wr_reg(`OFS_IRQ_STATUS, 16'h0003);
        rd_chk(`OFS_IRQ_STATUS, 16'h0000);
        wr_reg(`OFS_IRQ_MASK, 16'h0002);
        irq_chk(1'b0);
        wr_reg(`OFS_IRQ_MASK, 16'h0003);
        $display("test overwrite done");
    endtask

    task automatic test_filter();
        wr_reg(`OFS_RX_PENDING, 16'hffff);
        wr_reg(`OFS_UNREAD_FLAGS, 16'hffff);
        w = map_id(rid, 1'b1);
        wr_reg(`OFS_MB0_ID_LOW, w[15:0]);
        wr_reg(`OFS_MB0_ID_HIGH, w[31:16]);
        node.frame(4'h0, rid ^ 29'h1, 1'b1);
        rd_chk(`OFS_RX_PENDING, 16'h0000);
        w = map_id(29'h1, 1'b0);
        wr_reg(`OFS_MASK_LOW, w[15:0]);
        node.frame(4'h0, rid ^ 29'h1, 1'b1);
        rd_chk(`OFS_RX_PENDING, 16'h0001);
        node.frame(4'h0, rid ^ 29'h10000000, 1'b1);
        rd_chk(`OFS_UNREAD_FLAGS, 16'h0000);
        w = map_id(29'h10000000, 1'b0);
        wr_reg(`OFS_MASK_HIGH, w[31:16]);
        node.frame(4'h0, rid ^ 29'h10000000, 1'b1);
        rd_chk(`OFS_UNREAD_FLAGS, 16'h0100);
        wr_reg(`OFS_MASK_LOW, 16'h0000);
        wr_reg(`OFS_MASK_HIGH, 16'h0000);
        w = map_id(rid, 1'b0);
        wr_reg(`OFS_MB0_ID_HIGH, w[31:16]);
        node.frame(4'h0, rid ^ 29'h1, 1'b0);
        wr_reg(`OFS_MB_SELECT, 16'h0000);
        @(posedge clk);
        rd_chk(`OFS_MB_ID_LOW, 16'h5554);
        chk_bit(rx_pending[0], 1'b1, "pending port");
        $display("test filter done");
    endtask

    // reset in mid-run while flags and counters are nonzero
    task automatic test_midreset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd_chk(`OFS_UNREAD_FLAGS, 16'h0000);
        rd_chk(`OFS_RX_ERR_COUNT, 16'h0000);
        rd_chk(`OFS_TX_ERR_COUNT, 16'h0000);
        rd_chk(`OFS_MASK_HIGH, 16'h0000);
        chk_bit(rx_pending[0], 1'b0, "pending port");
        $display("test midreset done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // main sequence after a four-cycle reset
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        test_reset();
        test_counters();
        test_overwrite();
        test_filter();
        test_midreset();
        finish_test();
    end

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #200000;
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
